// ### hdl/otsb_ctrl.sv
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Auto scan powers supply 4 ms per 512 ms
// - Wait 1 ms after supply on before comparing
// - Sense below reference after settling means fail
// - External temperature selected keeps supply on
// - Scan disable bit stops periodic scan only
// - Force bit keeps supply on continuously
// - Over-temperature turns switches, balancing off, sets flag
// - Shutdown holds until indication recovers
// - Switch and balance writes ignored during shutdown
// - Internal response disable skips internal shutdown
// - External response disable skips external shutdown
// - Exactly one quantity routed to monitor output
// - One balance bit per cell, gated by shutdown
// - Overcurrent or short flags also raise supply
// - Automatic switch-off clears switch control bits
module otsb_ctrl
  import otsb_pkg::*;
#(
  parameter int WIN_CYC = SCAN_WIN_CYC,
  parameter int PER_CYC = SCAN_PER_CYC,
  parameter int SET_CYC = SETTLE_CYC
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [ADDR_W-1:0]    paddr,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 thermistor_sense_in,
  input  wire logic                 internal_overtemp_in,
  input  wire logic                 charge_overcurrent_flag,
  input  wire logic                 discharge_overcurrent_flag,
  input  wire logic                 short_circuit_flag,
  output logic                      thermistor_supply_out,
  output logic                      charge_switch_on,
  output logic                      discharge_switch_on,
  output logic [NUM_CELLS-1:0]      balance_en,
  output logic [3:0]                monitor_select,
  output logic [NUM_SRC-1:0]        analog_monitor_out,
  output logic                      irq
);

  ////////////////////////////////////////////////////////////
  // Decoding helpers

  // Selector code to one-hot route; bad codes fall back to cell 1
  function automatic logic [NUM_SRC-1:0] route_of(input logic [3:0] sel);
    logic [NUM_SRC-1:0] r;
    r = '0;
    if (sel < 4'(NUM_SRC)) begin
      r[sel] = 1'b1;
    end else begin
      r[0] = 1'b1;
    end
    return r;
  endfunction

  // Word offset match for an APB address
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] ofs);
    return a == ofs;
  endfunction

  ////////////////////////////////////////////////////////////
  // State
  otsb_ctrl_t           ctrl_ff;     // Host control bits
  logic [NUM_CELLS-1:0] bal_ff;      // Per-cell balance requests
  logic [IRQ_W-1:0]     ist_ff;      // Sticky events
  logic [IRQ_W-1:0]     ien_ff;      // Event enables
  logic [PER_W-1:0]     per_ff;      // Scan period position
  logic                 int_ot_ff;   // Internal over-temp flag
  logic                 ext_ot_ff;   // External over-temp flag
  logic                 shd_ff;      // Shutdown last cycle
  logic                 sup_ff;      // Registered supply output
  logic [31:0]          prdata_ff;   // Read data, latched at setup

  otsb_ctrl_t           nxt_ctrl;
  logic [NUM_CELLS-1:0] nxt_bal;
  logic [IRQ_W-1:0]     nxt_ist;
  logic [IRQ_W-1:0]     nxt_ien;
  logic [PER_W-1:0]     nxt_per;
  logic                 nxt_int_ot;
  logic                 nxt_ext_ot;
  logic                 nxt_sup;
  logic [31:0]          nxt_prdata;

  ////////////////////////////////////////////////////////////
  // APB decode
  logic wr_en;      // Write takes effect this edge
  logic rd_setup;   // Read setup cycle
  logic sel_ctrl;
  logic sel_bal;
  logic sel_stat;
  logic sel_ist;
  logic sel_iclr;
  logic sel_ien;
  logic mapped;

  assign sel_ctrl = hit(paddr, OFS_CTRL);
  assign sel_bal  = hit(paddr, OFS_BAL);
  assign sel_stat = hit(paddr, OFS_STAT);
  assign sel_ist  = hit(paddr, OFS_IST);
  assign sel_iclr = hit(paddr, OFS_ICLR);
  assign sel_ien  = hit(paddr, OFS_IEN);
  assign mapped   = sel_ctrl | sel_bal | sel_stat | sel_ist
                  | sel_iclr | sel_ien;
  assign wr_en    = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;

  // Zero wait states; unmapped access answers with an error
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  // Latching at setup keeps prdata steady through the access phase
  assign prdata  = prdata_ff;

  ////////////////////////////////////////////////////////////
  // Thermistor supply scheduling
  logic per_end;    // Last cycle of the scan period
  logic auto_win;   // Automatic scan window open
  logic manual_sel; // Host selected external temperature
  logic oc_wake;    // Overcurrent wake request
  logic settled;    // Supply on long enough to compare

  assign per_end = (per_ff == PER_W'(PER_CYC - 1));
  assign nxt_per = per_end ? '0 : per_ff + 1'b1;
  assign auto_win = !ctrl_ff.auto_scan_disable
                 && (per_ff < PER_W'(WIN_CYC));
  assign manual_sel = (ctrl_ff.monitor_select == SEL_EXT_TEMP);
  assign oc_wake = charge_overcurrent_flag | discharge_overcurrent_flag
                 | short_circuit_flag;
  assign nxt_sup = auto_win | manual_sel | oc_wake
                 | ctrl_ff.thermistor_supply_force;
  assign thermistor_supply_out = sup_ff;

  // Settling timer restarts at each turn-on
  otsb_settle_timer #(
    .COUNT (SET_CYC)
  ) u_settle (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (sup_ff),
    .done    (settled)
  );

  ////////////////////////////////////////////////////////////
  // Over-temperature detection and shutdown
  logic ext_fail;   // Qualified external failure
  logic shutdown;   // Protective shutdown in force

  assign ext_fail   = settled && thermistor_sense_in;
  // Flag follows the qualified compare, holds while unpowered
  assign nxt_ext_ot = settled ? ext_fail : ext_ot_ff;
  assign nxt_int_ot = internal_overtemp_in;
  assign shutdown   = (int_ot_ff
                    && !ctrl_ff.internal_overtemp_response_disable)
                   || (ext_ot_ff
                    && !ctrl_ff.external_overtemp_response_disable);

  ////////////////////////////////////////////////////////////
  // Register write paths
  otsb_ctrl_t wctrl; // Write data viewed as control layout

  assign wctrl = otsb_ctrl_t'(pwdata[9:0]);

  // Control: switch bits cleared and locked during shutdown
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (wr_en && sel_ctrl) begin
      nxt_ctrl = wctrl;
    end
    if (shutdown) begin
      nxt_ctrl.charge_switch_ctrl    = 1'b0;
      nxt_ctrl.discharge_switch_ctrl = 1'b0;
    end
  end

  // Balance writes ignored during shutdown
  assign nxt_bal = (wr_en && sel_bal && !shutdown)
                 ? pwdata[NUM_CELLS-1:0] : bal_ff;

  ////////////////////////////////////////////////////////////
  // Events and interrupt
  logic [IRQ_W-1:0] ev;   // One-cycle event pulses
  logic [IRQ_W-1:0] clr;  // Clear mask from host

  assign ev[IRQ_INT] = nxt_int_ot && !int_ot_ff;
  assign ev[IRQ_EXT] = nxt_ext_ot && !ext_ot_ff;
  assign ev[IRQ_SHD] = shutdown && !shd_ff;
  assign clr     = (wr_en && sel_iclr) ? pwdata[IRQ_W-1:0] : '0;
  // Set wins over a clear in the same cycle
  assign nxt_ist = (ist_ff & ~clr) | ev;
  assign nxt_ien = (wr_en && sel_ien) ? pwdata[IRQ_W-1:0] : ien_ff;
  assign irq     = |(ist_ff & ien_ff);

  ////////////////////////////////////////////////////////////
  // Outputs
  otsb_stat_t stat;

  assign stat = '{settled: settled, supply_on: sup_ff,
                  shutdown: shutdown,
                  external_overtemp_flag: ext_ot_ff,
                  internal_overtemp_flag: int_ot_ff};
  assign charge_switch_on    = ctrl_ff.charge_switch_ctrl;
  assign discharge_switch_on = ctrl_ff.discharge_switch_ctrl;
  assign balance_en          = shutdown ? '0 : bal_ff;
  assign monitor_select      = ctrl_ff.monitor_select;
  assign analog_monitor_out  = route_of(ctrl_ff.monitor_select);

  // Read mux, sampled in the setup cycle
  always_comb begin
    nxt_prdata = prdata_ff;
    if (rd_setup) begin
      nxt_prdata = '0;
      if (sel_ctrl) begin
        nxt_prdata[9:0] = ctrl_ff;
      end else if (sel_bal) begin
        nxt_prdata[NUM_CELLS-1:0] = bal_ff;
      end else if (sel_stat) begin
        nxt_prdata[4:0] = stat;
      end else if (sel_ist) begin
        nxt_prdata[IRQ_W-1:0] = ist_ff;
      end else if (sel_ien) begin
        nxt_prdata[IRQ_W-1:0] = ien_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff   <= CTRL_RST;
      bal_ff    <= BAL_RST;
      ist_ff    <= '0;
      ien_ff    <= IEN_RST;
      per_ff    <= '0;
      int_ot_ff <= 1'b0;
      ext_ot_ff <= 1'b0;
      shd_ff    <= 1'b0;
      sup_ff    <= 1'b0;
      prdata_ff <= '0;
    end else begin
      ctrl_ff   <= nxt_ctrl;
      bal_ff    <= nxt_bal;
      ist_ff    <= nxt_ist;
      ien_ff    <= nxt_ien;
      per_ff    <= nxt_per;
      int_ot_ff <= nxt_int_ot;
      ext_ot_ff <= nxt_ext_ot;
      shd_ff    <= shutdown;
      sup_ff    <= nxt_sup;
      prdata_ff <= nxt_prdata;
    end
  end

  ////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Supply on duration while settling, for the settle check
  logic [SET_W-1:0] on_cnt_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_cnt_ff <= '0;
    end else begin
      on_cnt_ff <= sup_ff ? on_cnt_ff + 1'b1 : '0;
    end
  end

  // Supply scheduling
  a_auto_window: assert property (
    auto_win |=> thermistor_supply_out)
    else $error("auto scan window left supply off");
  a_period_wrap: assert property (
    per_end |=> per_ff == '0 ##1 per_ff == PER_W'(1))
    else $error("scan period counter wrap wrong");
  a_settle_wait: assert property (
    $rose(settled) |-> on_cnt_ff == SET_W'(SET_CYC))
    else $error("compare qualified at wrong time");
  // Detection, shutdown and manual, disabled or forced supply
  a_ext_fail: assert property (
    settled && thermistor_sense_in |=> ext_ot_ff)
    else $error("external fail not flagged");
  a_manual_on: assert property (
    manual_sel [*2] |-> thermistor_supply_out)
    else $error("manual selection left supply off");
  a_scan_off: assert property (
    ctrl_ff.auto_scan_disable && !manual_sel && !oc_wake
    && !ctrl_ff.thermistor_supply_force |=> !thermistor_supply_out)
    else $error("supply on with scan disabled");
  a_force_on: assert property (
    ctrl_ff.thermistor_supply_force |=> thermistor_supply_out)
    else $error("force bit did not hold supply");
  a_shut_off: assert property (
    shutdown |-> (balance_en == '0)
                 ##1 (!charge_switch_on && !discharge_switch_on))
    else $error("shutdown left switch or balance on");
  a_shut_lock: assert property (
    shutdown && $past(shutdown) |-> balance_en == '0
    && $stable(bal_ff))
    else $error("balance changed during shutdown");
  a_int_dis: assert property (
    ctrl_ff.internal_overtemp_response_disable && !ext_ot_ff |-> !shutdown)
    else $error("internal shutdown despite disable");
  a_ext_dis: assert property (
    ctrl_ff.external_overtemp_response_disable && !int_ot_ff |-> !shutdown)
    else $error("external shutdown despite disable");
  // Monitor route, wake and switch bit clear
  a_route_one: assert property (
    $onehot(analog_monitor_out))
    else $error("monitor route not one-hot");
  a_oc_wake: assert property (
    oc_wake |=> thermistor_supply_out)
    else $error("overcurrent did not raise supply");
  a_ctrl_clear: assert property (
    shutdown |=> !ctrl_ff.charge_switch_ctrl
                 && !ctrl_ff.discharge_switch_ctrl)
    else $error("switch bits not cleared");
  // Sticky events: a shutdown entry is recorded and kept until cleared
  a_event_set: assert property (
    $rose(shutdown) |=> ist_ff[IRQ_SHD])
    else $error("shutdown event not recorded");
  a_event_hold: assert property (
    ist_ff[IRQ_SHD] && !clr[IRQ_SHD] |=> ist_ff[IRQ_SHD])
    else $error("shutdown event lost without clear");

  // Main scenarios reached
  c_auto_scan: cover property ($rose(auto_win));
  c_ext_shut:  cover property ($rose(ext_ot_ff) ##1 shutdown);
  c_recover:   cover property ($fell(shutdown));
  c_irq:       cover property ($rose(irq));

endmodule
`default_nettype wire

// ### hdl/otsb_pkg.sv
package otsb_pkg;

  ////////////////////////////////////////////////////////////
  // Clock and timing
  localparam int CLK_MHZ      = 25;       // Bus clock in MHz
  localparam int SCAN_WIN_US  = 4000;     // Scan window, 4 ms
  localparam int SCAN_PER_US  = 512000;   // Scan period, 512 ms
  localparam int SETTLE_US    = 1000;     // Settling, 1 ms
  localparam int SCAN_WIN_CYC = SCAN_WIN_US * CLK_MHZ;
  localparam int SCAN_PER_CYC = SCAN_PER_US * CLK_MHZ;
  localparam int SETTLE_CYC   = SETTLE_US * CLK_MHZ;
  localparam int PER_W        = 24;       // Period counter width
  localparam int SET_W        = 24;       // Settle counter width

  ////////////////////////////////////////////////////////////
  // Monitor multiplexer
  localparam int       NUM_CELLS    = 7;     // Cells in series
  localparam int       NUM_SRC      = 9;     // Cells plus two temps
  localparam logic [3:0] SEL_INT_TEMP = 4'h7; // Internal temperature
  localparam logic [3:0] SEL_EXT_TEMP = 4'h8; // External temperature

  ////////////////////////////////////////////////////////////
  // Register map, byte addresses
  localparam int       ADDR_W   = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00; // Control bits
  localparam logic [7:0] OFS_BAL  = 8'h04; // Cell balance enables
  localparam logic [7:0] OFS_STAT = 8'h08; // Live status, read only
  localparam logic [7:0] OFS_IST  = 8'h0c; // Sticky events, read only
  localparam logic [7:0] OFS_ICLR = 8'h10; // Event clear, write only
  localparam logic [7:0] OFS_IEN  = 8'h14; // Event enable

  // Event bit positions
  localparam int IRQ_INT = 0; // Internal over-temperature seen
  localparam int IRQ_EXT = 1; // External over-temperature seen
  localparam int IRQ_SHD = 2; // Automatic shutdown entered
  localparam int IRQ_W   = 3;

  ////////////////////////////////////////////////////////////
  // Control register layout, low bits of the word
  typedef struct packed {
    logic [3:0] monitor_select;                     // [9:6]
    logic       external_overtemp_response_disable; // [5]
    logic       internal_overtemp_response_disable; // [4]
    logic       thermistor_supply_force;            // [3]
    logic       auto_scan_disable;                  // [2]
    logic       discharge_switch_ctrl;              // [1]
    logic       charge_switch_ctrl;                 // [0]
  } otsb_ctrl_t;

  // Live status layout
  typedef struct packed {
    logic settled;                // [4] comparison qualified
    logic supply_on;              // [3] thermistor supply state
    logic shutdown;               // [2] protective shutdown
    logic external_overtemp_flag; // [1]
    logic internal_overtemp_flag; // [0]
  } otsb_stat_t;

  localparam otsb_ctrl_t CTRL_RST = '0;
  localparam logic [NUM_CELLS-1:0] BAL_RST = '0;
  localparam logic [IRQ_W-1:0]     IEN_RST = '0;

endpackage

// ### hdl/otsb_settle_timer.sv
`timescale 1ns/1ps
`default_nettype none
// Counts cycles while run is high; done once COUNT reached
module otsb_settle_timer
  import otsb_pkg::*;
#(
  parameter int COUNT = SETTLE_CYC
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic run,
  output logic      done
);

  logic [SET_W-1:0] cnt_ff;  // Cycles since run rose
  logic [SET_W-1:0] nxt_cnt; // Next count
  logic             at_end;  // Target reached

  assign at_end  = (cnt_ff == SET_W'(COUNT));
  assign nxt_cnt = !run ? '0 : (at_end ? cnt_ff : cnt_ff + 1'b1);
  assign done    = run && at_end;

  // Restart on every drop of run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

endmodule
`default_nettype wire

// ### verification/otsb_therm_model.sv
`timescale 1ns/1ps
`default_nettype none
// Thermistor divider and comparator as seen at the sense pin
module otsb_therm_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic supply,
  input  wire logic hot,
  output logic      sense
);
  logic [1:0] on_cnt_ff; // Cycles since the divider got power
  logic       junk_ff;   // Pattern of an unpowered comparator

  ////////////////////////////////////////////////////////////
  // Divider needs two cycles to charge after power-up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_cnt_ff <= 2'h0;
      junk_ff   <= 1'b0;
    end else begin
      junk_ff <= ~junk_ff;
      if (!supply) begin
        on_cnt_ff <= 2'h0;
      end else if (on_cnt_ff != 2'h3) begin
        on_cnt_ff <= on_cnt_ff + 2'h1;
      end
    end
  end

  // Unpowered or charging divider gives a toggling answer
  assign sense = (supply && on_cnt_ff >= 2'h2) ? hot : junk_ff;
endmodule
`default_nettype wire

// ### verification/tb_otsb_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module tb_otsb_ctrl;
  import otsb_pkg::*;
  localparam int WIN = 8;     // Scan window in cycles
  localparam int PER = 64;    // Scan period in cycles
  localparam int SET = 4;     // Settling in cycles
  localparam int TMO = 20000; // Hang limit in cycles

  logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0]           paddr;
  logic [31:0]          pwdata, prdata, rd;
  logic                 sense, int_hot, hot, supply, chg_on, dis_on, irq;
  logic [2:0]           oc;
  logic [NUM_CELLS-1:0] bal;
  logic [3:0]           msel;
  logic [NUM_SRC-1:0]   amon;
  int                   n_mismatch, cmp_count, cyc, k;

  ////////////////////////////////////////////////////////////
  // Device and far-side divider
  otsb_ctrl #(.WIN_CYC(WIN), .PER_CYC(PER), .SET_CYC(SET)) u_otsb_ctrl (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .thermistor_sense_in(sense), .internal_overtemp_in(int_hot),
    .charge_overcurrent_flag(oc[0]), .discharge_overcurrent_flag(oc[1]),
    .short_circuit_flag(oc[2]), .thermistor_supply_out(supply),
    .charge_switch_on(chg_on), .discharge_switch_on(dis_on), .balance_en(bal),
    .monitor_select(msel), .analog_monitor_out(amon), .irq(irq));
  otsb_therm_model u_otsb_therm_model (
    .pclk(pclk), .presetn(presetn), .supply(supply), .hot(hot), .sense(sense));

  ////////////////////////////////////////////////////////////
  // Clock and hang limit
  always #20 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == TMO) begin
      n_mismatch++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////
  // Compare, count and report
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("Compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge pclk);
  endtask
  // APB transfer: setup, then access until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // Supply-on cycles over a span
  task automatic count_high(input int n);
    k = 0;
    repeat (n) begin
      @(negedge pclk);
      if (supply === 1'b1) k++;
    end
  endtask

  ////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0;
    int_hot = 0; hot = 0; oc = '0; cyc = 0; n_mismatch = 0; cmp_count = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    count_high(2 * PER);
    chk("auto scan", k, 2 * WIN);
    apb(0, OFS_STAT, 0);
    chk("no false fail", rd[1], 0);
    apb(1, OFS_CTRL, 32'h4);
    tick(WIN + 2);
    count_high(PER);
    chk("scan off", k, 0);
    $display("Test scan done");
    // Monitor codes 0 to 9, external one holds supply
    for (int c = 0; c < 10; c++) begin
      apb(1, OFS_CTRL, 32'h4 | (c << 6));
      tick(2);
      chk("select", msel, c);
      chk("route", amon, (c < 9) ? (9'h001 << c) : 9'h001);
      if (c == 8) begin
        count_high(3 * WIN);
        chk("manual hold", k, 3 * WIN);
        apb(0, OFS_STAT, 0);
        chk("manual settled", rd[4:3], 2'h3);
      end
    end
    chk("manual off", supply, 0);
    apb(1, OFS_CTRL, 32'hc);
    tick(2);
    count_high(PER);
    chk("force", k, PER);
    $display("Test monitor done");
    // External fail after settling, then shutdown
    apb(1, OFS_CTRL, 32'h7);
    apb(1, OFS_BAL, 32'h7f);
    tick(3);
    chk("bal on", bal, 7'h7f);
    chk("switch on", {dis_on, chg_on}, 2'h3);
    @(posedge pclk) hot <= 1'b1;
    apb(1, OFS_CTRL, 32'hf);
    while (supply !== 1'b1) @(negedge pclk);
    tick(SET - 1);
    chk("before settle", bal, 7'h7f);
    tick(4);
    chk("ext shutdown", bal, 0);
    chk("switch off", {dis_on, chg_on}, 0);
    apb(0, OFS_STAT, 0);
    chk("stat", rd, 32'h1e);
    apb(1, OFS_CTRL, 32'h1cf);
    apb(1, OFS_BAL, 32'h55);
    tick(2);
    chk("sel in shutdown", msel, 4'h7);
    apb(0, OFS_CTRL, 0);
    chk("ctrl ignored", rd, 32'h1cc);
    apb(0, OFS_BAL, 0);
    chk("bal ignored", rd, 32'h7f);
    hot <= 1'b0;
    tick(4);
    chk("recover", bal, 7'h7f);
    chk("still off", chg_on, 0);
    $display("Test external done");
    // Sticky events, enable, clear
    apb(0, OFS_IST, 0);
    chk("events", rd, 32'h6);
    apb(1, OFS_IEN, 32'h2);
    tick(2);
    chk("irq on", irq, 1);
    apb(1, OFS_IEN, 32'h0);
    tick(2);
    chk("irq masked", irq, 0);
    apb(1, OFS_ICLR, 32'h7);
    apb(1, OFS_IEN, 32'h7);
    tick(2);
    chk("irq clear", irq, 0);
    apb(0, OFS_IST, 0);
    chk("events clear", rd, 0);
    apb(0, 8'h40, 0);
    chk("unmapped err", er, 1'b1);
    chk("unmapped data", rd, 32'h0);
    chk("ready", pready, 1'b1);
    $display("Test interrupt done");
    // Internal fail with and without response, external fail without response
    apb(1, OFS_CTRL, 32'h7);
    int_hot <= 1'b1;
    tick(4);
    chk("int shutdown", {bal, dis_on, chg_on}, 0);
    @(posedge pclk) int_hot <= 1'b0;
    tick(4);
    chk("int recover", bal, 7'h7f);
    apb(1, OFS_CTRL, 32'h17);
    int_hot <= 1'b1;
    tick(4);
    chk("int disabled", {bal, dis_on, chg_on}, 9'h1ff);
    @(posedge pclk) int_hot <= 1'b0;
    apb(1, OFS_CTRL, 32'h2f);
    hot <= 1'b1;
    tick(SET + 6);
    chk("ext disabled", {bal, dis_on, chg_on}, 9'h1ff);
    @(posedge pclk) hot <= 1'b0;
    $display("Test response disable done");
    // Each fault flag raises the supply
    apb(1, OFS_CTRL, 32'h4);
    for (int i = 0; i < 3; i++) begin
      tick(3);
      chk("oc idle", supply, 0);
      @(posedge pclk) oc <= 3'h1 << i;
      tick(3);
      chk("oc wake", supply, 1);
      @(posedge pclk) oc <= 3'h0;
    end
    $display("Test wake done");
    give_verdict();
  end
endmodule
`default_nettype wire
